//--- plrc_pkg.sv
// Shared constants for the pin, lamp and reset control block.
package plrc_pkg;
    localparam int CLK_HZ = 50_000_000;
    localparam int CLK_PERIOD_NS = 20;
    localparam int RESET_MIN_NS = 1000;
    localparam int RESET_MIN_CYCLES = (RESET_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int BLINK_PERIOD_MS = 50;
    localparam int BLINK_CYCLES = (CLK_HZ / 1000) * BLINK_PERIOD_MS;
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_IRQ_STATUS = 8'h08;
    localparam logic [7:0] ADDR_IRQ_CLEAR = 8'h0C;
    localparam logic [7:0] ADDR_IRQ_ENABLE = 8'h10;
    localparam int CTRL_PIN_IRQ_FUNC = 0;
    localparam int CTRL_PIN_IRQ_EN = 1;
    localparam int CTRL_DUPLEX_LAMP = 2;
    localparam logic [2:0] CTRL_RESET = 3'h0;
    localparam int IRQ_LINK_CHANGE = 0;
    localparam int IRQ_SPEED_CHANGE = 1;
    localparam int IRQ_COLLISION = 2;
    localparam int IRQ_POWERDOWN = 3;
    localparam int IRQ_W = 4;
    localparam logic [IRQ_W-1:0] IRQ_RESET = 4'h0;
    typedef enum logic [1:0] {
        LED_MODE1 = 2'b01,
        LED_MODE2 = 2'b11,
        LED_MODE3 = 2'b10
    } plrc_led_mode_t;
endpackage

//--- plrc_top.sv
// Reference clock, status lamps, reset and shared power-down/interrupt pin control.
//
// Design decisions made here: register access over APB and the register offsets.
`timescale 1ns/1ns
`default_nettype none
module plrc_top
    import plrc_pkg::*;
#(
    parameter int unsigned BLINK_TICKS = BLINK_CYCLES
)(
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic ref_clock_in,
    output logic ref_clock_out,
    output logic crystal_drive_out,
    input wire logic strap_rmii,
    input wire logic [1:0] strap_led_mode,
    input wire logic link_good,
    input wire logic speed_100,
    input wire logic full_duplex,
    input wire logic tx_active,
    input wire logic rx_active,
    input wire logic collision,
    output logic link_status_lamp,
    output logic speed_status_lamp,
    output logic activity_collision_lamp,
    input wire logic powerdown_or_irq_pin_in,
    output logic powerdown_or_irq_pin_out,
    output logic powerdown_or_irq_pin_oe,
    output logic powerdown_req,
    output logic irq,
    input wire logic trst_n,
    output logic test_logic_reset,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr
);
    logic rst_meta_q;
    logic rst_sync_q;
    logic [7:0] hold_cnt_q;
    logic rst_int_n_q;
    logic rmii_q;
    plrc_led_mode_t led_mode_q;
    logic div_q;
    logic [31:0] blink_cnt_q;
    logic blink_tick;
    logic act_now;
    logic act_seen_q;
    logic act_hold_q;
    logic col_seen_q;
    logic col_hold_q;
    logic blink_q;
    logic [2:0] ctrl_q;
    logic [IRQ_W-1:0] irq_status_q;
    logic [IRQ_W-1:0] irq_enable_q;
    logic [IRQ_W-1:0] irq_event;
    logic [IRQ_W-1:0] irq_clear;
    logic link_prev_q;
    logic speed_prev_q;
    logic col_prev_q;
    logic pd_prev_q;
    logic pin_irq_mode;
    logic pd_active;
    logic wr_en;
    logic addr_ok;

    function automatic logic addr_mapped(input logic [7:0] a);
        addr_mapped = (a == ADDR_CTRL) || (a == ADDR_STATUS) || (a == ADDR_IRQ_STATUS) ||
                      (a == ADDR_IRQ_CLEAR) || (a == ADDR_IRQ_ENABLE);
    endfunction

    function automatic plrc_led_mode_t decode_mode(input logic [1:0] s);
        // Strap value zero has no mode of its own, so it falls back to mode 1.
        if (s == 2'h2)
        begin
            decode_mode = LED_MODE2;
        end
        else if (s == 2'h3)
        begin
            decode_mode = LED_MODE3;
        end
        else
        begin
            decode_mode = LED_MODE1;
        end
    endfunction

    // The raw reset only ever asynchronously clears; release passes two flops.
    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            rst_meta_q <= 1'b0;
            rst_sync_q <= 1'b0;
        end
        else
        begin
            rst_meta_q <= 1'b1;
            rst_sync_q <= rst_meta_q;
        end
    end

    // Internal reset stays low for the minimum reset time after release.
    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            hold_cnt_q <= 8'h00;
            rst_int_n_q <= 1'b0;
        end
        else if (rst_sync_q && !rst_int_n_q)
        begin
            if (hold_cnt_q == 8'(RESET_MIN_CYCLES - 1))
            begin
                rst_int_n_q <= 1'b1;
            end
            else
            begin
                hold_cnt_q <= hold_cnt_q + 8'h01;
            end
        end
    end

    // Straps are sampled throughout the hold window; the last sample stays.
    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            rmii_q <= 1'b0;
            led_mode_q <= LED_MODE1;
        end
        else if (rst_sync_q && !rst_int_n_q)
        begin
            rmii_q <= strap_rmii;
            led_mode_q <= decode_mode(strap_led_mode);
        end
    end

    always_ff @(posedge clk_sys or negedge rst_int_n_q)
    begin
        if (!rst_int_n_q)
        begin
            div_q <= 1'b0;
        end
        else
        begin
            div_q <= rmii_q ? 1'b0 : ~div_q;
        end
    end

    // The 50 MHz case forwards the core clock itself; no flop can toggle that fast.
    assign ref_clock_out = rmii_q ? clk_sys : div_q;
    assign crystal_drive_out = ~ref_clock_in;
    assign test_logic_reset = ~trst_n;

    always_ff @(posedge clk_sys or negedge rst_int_n_q)
    begin
        if (!rst_int_n_q)
        begin
            blink_cnt_q <= 32'h0;
        end
        else if (blink_tick)
        begin
            blink_cnt_q <= 32'h0;
        end
        else
        begin
            blink_cnt_q <= blink_cnt_q + 32'h1;
        end
    end

    assign blink_tick = (blink_cnt_q == BLINK_TICKS - 1);
    assign act_now = tx_active || rx_active;

    // Short frames are caught between ticks and shown for a whole period.
    always_ff @(posedge clk_sys or negedge rst_int_n_q)
    begin
        if (!rst_int_n_q)
        begin
            act_seen_q <= 1'b0;
            act_hold_q <= 1'b0;
            col_seen_q <= 1'b0;
            col_hold_q <= 1'b0;
            blink_q <= 1'b0;
        end
        else if (blink_tick)
        begin
            act_seen_q <= 1'b0;
            act_hold_q <= act_seen_q || act_now;
            col_seen_q <= 1'b0;
            col_hold_q <= col_seen_q || collision;
            blink_q <= (act_seen_q || act_now) ? ~blink_q : 1'b0;
        end
        else
        begin
            act_seen_q <= act_seen_q || act_now;
            col_seen_q <= col_seen_q || collision;
        end
    end

    assign pin_irq_mode = ctrl_q[CTRL_PIN_IRQ_FUNC];
    assign pd_active = !pin_irq_mode && !powerdown_or_irq_pin_in;
    assign powerdown_req = pd_active;

    // Lamps go dark while powered down.
    always_ff @(posedge clk_sys or negedge rst_int_n_q)
    begin
        if (!rst_int_n_q)
        begin
            link_status_lamp <= 1'b0;
            speed_status_lamp <= 1'b0;
            activity_collision_lamp <= 1'b0;
        end
        else if (pd_active)
        begin
            link_status_lamp <= 1'b0;
            speed_status_lamp <= 1'b0;
            activity_collision_lamp <= 1'b0;
        end
        else
        begin
            speed_status_lamp <= speed_100;
            unique case (led_mode_q)
                LED_MODE1:
                begin
                    link_status_lamp <= link_good;
                    activity_collision_lamp <= act_now || act_hold_q;
                end
                LED_MODE2:
                begin
                    link_status_lamp <= link_good && !blink_q;
                    activity_collision_lamp <= collision || col_hold_q;
                end
                LED_MODE3:
                begin
                    link_status_lamp <= link_good && !blink_q;
                    activity_collision_lamp <= ctrl_q[CTRL_DUPLEX_LAMP] ? full_duplex :
                                               (collision || col_hold_q);
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge rst_int_n_q)
    begin
        if (!rst_int_n_q)
        begin
            link_prev_q <= 1'b0;
            speed_prev_q <= 1'b0;
            col_prev_q <= 1'b0;
            pd_prev_q <= 1'b0;
        end
        else
        begin
            link_prev_q <= link_good;
            speed_prev_q <= speed_100;
            col_prev_q <= collision;
            pd_prev_q <= pd_active;
        end
    end

    assign irq_event[IRQ_LINK_CHANGE] = link_good != link_prev_q;
    assign irq_event[IRQ_SPEED_CHANGE] = speed_100 != speed_prev_q;
    assign irq_event[IRQ_COLLISION] = collision && !col_prev_q;
    assign irq_event[IRQ_POWERDOWN] = pd_active && !pd_prev_q;

    assign pready = 1'b1;
    assign addr_ok = addr_mapped(paddr);
    assign pslverr = psel && penable && !addr_ok;
    assign wr_en = psel && penable && pwrite && addr_ok;
    assign irq_clear = (wr_en && paddr == ADDR_IRQ_CLEAR) ? pwdata[IRQ_W-1:0] : IRQ_RESET;

    always_ff @(posedge clk_sys or negedge rst_int_n_q)
    begin
        if (!rst_int_n_q)
        begin
            ctrl_q <= CTRL_RESET;
            irq_enable_q <= IRQ_RESET;
        end
        else if (wr_en && paddr == ADDR_CTRL)
        begin
            ctrl_q <= pwdata[2:0];
        end
        else if (wr_en && paddr == ADDR_IRQ_ENABLE)
        begin
            irq_enable_q <= pwdata[IRQ_W-1:0];
        end
    end

    // A new event outranks a clear written in the same cycle.
    always_ff @(posedge clk_sys or negedge rst_int_n_q)
    begin
        if (!rst_int_n_q)
        begin
            irq_status_q <= IRQ_RESET;
        end
        else
        begin
            irq_status_q <= (irq_status_q & ~irq_clear) | irq_event;
        end
    end

    assign irq = |(irq_status_q & irq_enable_q);
    assign powerdown_or_irq_pin_out = 1'b0;
    assign powerdown_or_irq_pin_oe = pin_irq_mode && ctrl_q[CTRL_PIN_IRQ_EN] && irq;

    // Read data is captured in the setup cycle and shown in the access phase.
    always_ff @(posedge clk_sys or negedge rst_int_n_q)
    begin
        if (!rst_int_n_q)
        begin
            prdata <= 32'h0;
        end
        else if (psel && !penable)
        begin
            if (paddr == ADDR_CTRL)
            begin
                prdata <= {29'h0, ctrl_q};
            end
            else if (paddr == ADDR_STATUS)
            begin
                prdata <= {24'h0, led_mode_q, rmii_q, pd_active, full_duplex, speed_100,
                           link_good, irq};
            end
            else if (paddr == ADDR_IRQ_STATUS)
            begin
                prdata <= {28'h0, irq_status_q};
            end
            else if (paddr == ADDR_IRQ_ENABLE)
            begin
                prdata <= {28'h0, irq_enable_q};
            end
            else
            begin
                prdata <= 32'h0;
            end
        end
    end

    a_ref_mii_toggle: assert property (@(posedge clk_sys) disable iff (!rst_int_n_q)
        (!rmii_q && $past(!rmii_q)) |=> (div_q != $past(div_q)))
        else $error("MII reference clock divider stopped.");
    a_ref_rmii_hold: assert property (@(posedge clk_sys) disable iff (!rst_int_n_q)
        rmii_q |=> !div_q)
        else $error("RMII divider not parked.");
    a_link_mode1: assert property (@(posedge clk_sys) disable iff (!rst_int_n_q)
        (led_mode_q == LED_MODE1 && !pd_active) |=> link_status_lamp == $past(link_good))
        else $error("Mode 1 link lamp wrong.");
    a_link_off_mode2: assert property (@(posedge clk_sys) disable iff (!rst_int_n_q)
        (led_mode_q != LED_MODE1 && !link_good) |=> !link_status_lamp)
        else $error("Link lamp lit without link.");
    a_speed_lamp: assert property (@(posedge clk_sys) disable iff (!rst_int_n_q)
        !pd_active |=> speed_status_lamp == $past(speed_100))
        else $error("Speed lamp wrong.");
    a_act_mode1: assert property (@(posedge clk_sys) disable iff (!rst_int_n_q)
        (led_mode_q == LED_MODE1 && act_now && !pd_active) |=> activity_collision_lamp)
        else $error("Activity lamp dark during activity.");
    a_col_mode2: assert property (@(posedge clk_sys) disable iff (!rst_int_n_q)
        (led_mode_q == LED_MODE2 && collision && !pd_active) |=> activity_collision_lamp)
        else $error("Collision lamp dark during collision.");
    a_duplex_mode3: assert property (@(posedge clk_sys) disable iff (!rst_int_n_q)
        (led_mode_q == LED_MODE3 && ctrl_q[CTRL_DUPLEX_LAMP] && !pd_active)
        |=> activity_collision_lamp == $past(full_duplex))
        else $error("Duplex lamp wrong.");
    a_pin_pd_input: assert property (@(posedge clk_sys) disable iff (!rst_int_n_q)
        !pin_irq_mode |-> !powerdown_or_irq_pin_oe && (powerdown_req == !powerdown_or_irq_pin_in))
        else $error("Shared pin not acting as power-down input.");
    a_pin_irq_drive: assert property (@(posedge clk_sys) disable iff (!rst_int_n_q)
        (pin_irq_mode && ctrl_q[CTRL_PIN_IRQ_EN])
        |-> (powerdown_or_irq_pin_oe == irq) && !powerdown_or_irq_pin_out)
        else $error("Shared pin interrupt drive wrong.");
    a_reset_hold: assert property (@(posedge clk_sys)
        $rose(rst_int_n_q) |-> hold_cnt_q == 8'(RESET_MIN_CYCLES - 1))
        else $error("Internal reset released early.");
endmodule
`default_nettype wire

//--- plrc_host_model.sv
// Host and board model: shared pin pull-up, host power-down drive and reference oscillator.
`timescale 1ns/1ns
`default_nettype none
module plrc_host_model (
    input wire logic pull_low,
    input wire logic dev_oe,
    input wire logic dev_out,
    output logic pin_level,
    output logic osc_clk
);
    initial osc_clk = 1'b0;
    // The board oscillator runs free, so the model never stops it.
    always #10 osc_clk = ~osc_clk;
    // The line idles high through its pull-up; either party may pull it low.
    assign pin_level = (pull_low || (dev_oe && !dev_out)) ? 1'b0 : 1'b1;
endmodule
`default_nettype wire

//--- plrc_top_bench.sv
// Self-checking bench for the pin, lamp and reset control block.
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, exp, got) \
    begin \
        n_compared++; \
        if ((got) !== (exp)) \
        begin \
            bad_count++; \
            $display("MISMATCH %s exp %h got %h", nm, exp, got); \
        end \
    end
module plrc_top_bench
    import plrc_pkg::*;
;
    logic clk_sys = 1'b0, nrst = 1'b0, strap_rmii = 1'b0, link_good = 1'b0, speed_100 = 1'b0;
    logic full_duplex = 1'b0, tx_active = 1'b0, rx_active = 1'b0, collision = 1'b0;
    logic trst_n = 1'b1, pull_low = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [1:0] strap_led_mode = 2'h1;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic ref_clock_in, ref_clock_out, crystal_drive_out, link_lamp, speed_lamp, act_lamp;
    logic pin_level, pin_out, pin_oe, powerdown_req, irq, test_logic_reset, pready, pslverr, er;
    int bad_count = 0, n_compared = 0, lk1, lk0, ac1, ac0;

    always #(CLK_PERIOD_NS / 2) clk_sys = ~clk_sys;

    plrc_top #(.BLINK_TICKS(8)) plrc_top_inst (.clk_sys(clk_sys), .nrst(nrst),
        .ref_clock_in(ref_clock_in), .ref_clock_out(ref_clock_out),
        .crystal_drive_out(crystal_drive_out), .strap_rmii(strap_rmii),
        .strap_led_mode(strap_led_mode), .link_good(link_good), .speed_100(speed_100),
        .full_duplex(full_duplex), .tx_active(tx_active), .rx_active(rx_active),
        .collision(collision), .link_status_lamp(link_lamp), .speed_status_lamp(speed_lamp),
        .activity_collision_lamp(act_lamp), .powerdown_or_irq_pin_in(pin_level),
        .powerdown_or_irq_pin_out(pin_out), .powerdown_or_irq_pin_oe(pin_oe),
        .powerdown_req(powerdown_req), .irq(irq), .trst_n(trst_n),
        .test_logic_reset(test_logic_reset), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

    plrc_host_model plrc_host_model_inst (.pull_low(pull_low), .dev_oe(pin_oe),
        .dev_out(pin_out), .pin_level(pin_level), .osc_clk(ref_clock_in));

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge clk_sys);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge clk_sys);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        if (n >= 20)
            bad_count++;
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // Lamps are sampled mid-cycle, where the registered outputs have settled.
    task automatic watch(input int n);
        lk1 = 0;
        lk0 = 0;
        ac1 = 0;
        ac0 = 0;
        repeat (n)
        begin
            @(negedge clk_sys);
            lk1 += (link_lamp === 1'b1);
            lk0 += (link_lamp === 1'b0);
            ac1 += (act_lamp === 1'b1);
            ac0 += (act_lamp === 1'b0);
        end
        @(posedge clk_sys);
    endtask

    // Link stays good across reset so the lamp shows when the internal hold ends.
    task automatic do_reset(input logic rm, input logic [1:0] md);
        @(posedge clk_sys);
        nrst <= 1'b0;
        link_good <= 1'b1;
        strap_rmii <= rm;
        strap_led_mode <= md;
        repeat (2) @(posedge clk_sys);
        `CHK("lamp in reset", 1'b0, link_lamp)
        nrst <= 1'b1;
        repeat (40) @(posedge clk_sys);
        `CHK("lamp in hold", 1'b0, link_lamp)
        repeat (20) @(posedge clk_sys);
        `CHK("lamp after hold", 1'b1, link_lamp)
        $display("reset done");
    endtask

    task automatic t_mode1();
        apb(1'b0, ADDR_CTRL, 32'h0);
        `CHK("ctrl reset", 32'h0, rd)
        apb(1'b0, ADDR_STATUS, 32'h0);
        `CHK("status mode", 3'b010, rd[7:5])
        `CHK("pin idle", 1'b0, pin_oe)
        repeat (3)
        begin
            @(posedge clk_sys);
            #5 `CHK("crystal drive", ~ref_clock_in, crystal_drive_out)
        end
        @(posedge clk_sys);
        speed_100 <= 1'b1;
        tx_active <= 1'b1;
        watch(20);
        `CHK("m1 link steady", 20, lk1)
        `CHK("m1 act", 1'b1, ac1 > 0)
        `CHK("speed on", 1'b1, speed_lamp)
        link_good <= 1'b0;
        speed_100 <= 1'b0;
        tx_active <= 1'b0;
        repeat (30) @(posedge clk_sys);
        watch(5);
        `CHK("m1 link off", 5, lk0)
        `CHK("m1 act off", 5, ac0)
        `CHK("speed off", 1'b0, speed_lamp)
        $display("mode1 test done");
    endtask

    task automatic t_mii_clk();
        logic p;
        @(posedge clk_sys);
        #5 p = ref_clock_out;
        repeat (3)
        begin
            @(posedge clk_sys);
            #5 `CHK("clk 25", ~p, ref_clock_out)
            p = ref_clock_out;
        end
        @(posedge clk_sys);
        $display("mii clock test done");
    endtask

    task automatic t_pin();
        pull_low <= 1'b1;
        repeat (3) @(posedge clk_sys);
        `CHK("pd req", 1'b1, powerdown_req)
        apb(1'b0, ADDR_IRQ_STATUS, 32'h0);
        `CHK("pd event", 1'b1, rd[IRQ_POWERDOWN])
        pull_low <= 1'b0;
        apb(1'b1, ADDR_IRQ_CLEAR, 32'hF);
        apb(1'b1, ADDR_CTRL, 32'h3);
        apb(1'b1, ADDR_IRQ_ENABLE, 32'h1);
        `CHK("irq idle", 1'b0, irq)
        link_good <= 1'b1;
        repeat (3) @(posedge clk_sys);
        `CHK("irq set", 1'b1, irq)
        `CHK("pin low", 1'b0, pin_level)
        `CHK("no pd in irq", 1'b0, powerdown_req)
        apb(1'b1, ADDR_IRQ_CLEAR, 32'h1);
        @(posedge clk_sys);
        `CHK("pin freed", 1'b1, pin_level)
        apb(1'b1, ADDR_IRQ_ENABLE, 32'h2);
        link_good <= 1'b0;
        apb(1'b0, ADDR_IRQ_STATUS, 32'h0);
        `CHK("sticky", 1'b1, rd[IRQ_LINK_CHANGE])
        `CHK("masked", 1'b0, irq)
        apb(1'b0, 8'h20, 32'h0);
        `CHK("unmapped", 33'h100000000, {er, rd})
        @(posedge clk_sys);
        trst_n <= 1'b0;
        #1 `CHK("test reset", 1'b1, test_logic_reset)
        @(posedge clk_sys);
        trst_n <= 1'b1;
        #1 `CHK("test reset off", 1'b0, test_logic_reset)
        $display("pin test done");
    endtask

    task automatic t_mode2();
        apb(1'b0, ADDR_CTRL, 32'h0);
        `CHK("ctrl again", 32'h0, rd)
        collision <= 1'b1;
        rx_active <= 1'b1;
        watch(40);
        `CHK("m2 blink", 1'b1, lk0 > 0 && lk1 > 0)
        `CHK("m2 col", 1'b1, ac1 > 0)
        collision <= 1'b0;
        rx_active <= 1'b0;
        repeat (30) @(posedge clk_sys);
        watch(10);
        `CHK("m2 col off", 10, ac0)
        `CHK("m2 link steady", 10, lk1)
        $display("mode2 test done");
    endtask

    task automatic t_mode3();
        @(posedge clk_sys);
        #5 `CHK("clk 50 hi", 1'b1, ref_clock_out)
        #10 `CHK("clk 50 lo", 1'b0, ref_clock_out)
        apb(1'b0, ADDR_STATUS, 32'h0);
        `CHK("status m3", 3'b101, rd[7:5])
        collision <= 1'b1;
        watch(20);
        `CHK("m3 col", 1'b1, ac1 > 0)
        collision <= 1'b0;
        apb(1'b1, ADDR_CTRL, 32'h4);
        full_duplex <= 1'b1;
        tx_active <= 1'b1;
        watch(40);
        `CHK("m3 duplex", 1'b1, ac1 > 0)
        `CHK("m3 blink", 1'b1, lk0 > 0 && lk1 > 0)
        full_duplex <= 1'b0;
        tx_active <= 1'b0;
        repeat (30) @(posedge clk_sys);
        watch(10);
        `CHK("m3 half", 10, ac0)
        $display("mode3 test done");
    endtask

    task automatic report_and_stop();
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // The whole sequence takes well under a tenth of this span.
    initial
    begin
        #400000;
        bad_count++;
        report_and_stop();
    end

    initial
    begin
        do_reset(1'b0, 2'h0);
        t_mode1();
        t_mii_clk();
        t_pin();
        do_reset(1'b0, 2'h2);
        t_mode2();
        do_reset(1'b1, 2'h3);
        t_mode3();
        report_and_stop();
    end
endmodule
`default_nettype wire
